// File: verilog/udt_pkg.sv
// Constants, register map and carrier types of the up/down timer unit.
// Assumes an APB master with 32-bit data and one aligned word per register.
//
// Functional notes
// - First timer sets its rollover flag only when count wraps from period to zero.
// - Second timer sets its rollover flag the same way in up mode.
// - Reset or the counter-clear bit sets the count to zero.
// - Count advances on a rising edge of one of four selectable sources.
// - Two-bit input divider scales the selected source when not zero.
// - First increment after a clear ignores the divider.
// - Compare channel flags a match when count steps onto its compare value.
// - A write to the timer control register clears the interrupt vector.
package udt_pkg;

  localparam int unsigned CNT_W = 16;
  localparam int unsigned NUM_CH = 3;

  // Register byte offsets; second timer adds TIMER_STRIDE to the per-timer ones, interrupt status and mask are global
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_COUNT = 8'h04;
  localparam logic [7:0] OFF_VECTOR = 8'h08;
  localparam logic [7:0] OFF_CCTL0 = 8'h10;
  localparam logic [7:0] OFF_CCR0 = 8'h20;
  localparam logic [7:0] TIMER_STRIDE = 8'h40;
  localparam logic [7:0] OFF_IRQ_STATUS = 8'h80;
  localparam logic [7:0] OFF_IRQ_MASK = 8'h84;

  // Control register fields
  localparam int unsigned CTL_SRC_LSB = 0;
  localparam int unsigned CTL_DIV_LSB = 2;
  localparam int unsigned CTL_MODE_BIT = 4;
  localparam int unsigned CTL_CLR_BIT = 5;
  localparam int unsigned CCTL_CMP_BIT = 0;

  // Clock source codes
  localparam logic [1:0] SRC_INV_INPUT = 2'h0;
  localparam logic [1:0] SRC_SUBSYSTEM = 2'h1;
  localparam logic [1:0] SRC_AUX = 2'h2;
  localparam logic [1:0] SRC_EXTERNAL = 2'h3;

  // Vector codes, highest priority lowest
  localparam logic [3:0] VEC_NONE = 4'h0;
  localparam logic [3:0] VEC_CH_BASE = 4'h2;
  localparam logic [3:0] VEC_ROLL = 4'hA;

  localparam logic [CNT_W-1:0] CNT_RST = 16'h0000;

  typedef enum logic [1:0] {
    UDT_STOP = 2'b01,
    UDT_UP = 2'b10
  } udt_mode_t;

  typedef struct packed {
    logic [1:0] src;
    logic [1:0] div;
    logic run;
  } udt_ctrl_t;

  // Interrupt status layout: per timer, rollover then channels
  localparam int unsigned IRQ_PER_TMR = NUM_CH + 1;
  localparam int unsigned IRQ_W = 2 * IRQ_PER_TMR;

endpackage

// File: verilog/udt_timer_unit.sv
// Two identical up-counting timers with compare channels, APB registers.
// Assumes count source inputs are synchronous to core_clk_i.
//
// Chosen here: register access over APB and the register offsets.
`timescale 1ns/1ps

module udt_timer_unit
  import udt_pkg::*;
(
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic reset_i,
  // Count sources, index 0 first timer
  input wire logic [1:0] inverted_input_clock_i,
  input wire logic subsystem_clock_i,
  input wire logic aux_clock_i,
  input wire logic external_count_clock_first_i,
  input wire logic external_count_clock_second_i,
  // APB slave
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  // Interrupt
  output logic irq_o
);

  ////////////////////////////////////////////////////////////////////////////
  // Bus decode

  wire apb_acc = psel_i & penable_i;
  wire apb_wr = apb_acc & pwrite_i;
  wire apb_rd = apb_acc & ~pwrite_i;
  wire tsel = paddr_i[6];
  wire [7:0] loc = {2'b00, paddr_i[5:0]};
  wire glob = paddr_i[7];

  function automatic logic [1:0] ch_of(input logic [7:0] a);
    ch_of = a[3:2];
  endfunction

  // Channel bank hit: exact word of an existing channel, no aliases
  function automatic logic in_bank(input logic [7:0] a,
      input logic [7:0] base);
    in_bank = (a[7:4] == base[7:4]) && (a[1:0] == 2'b00) &&
      (ch_of(a) < 2'(NUM_CH));
  endfunction

  // Flag position of a channel vector code, rollover at position 0
  function automatic logic [1:0] vec_idx(input logic [3:0] v);
    logic [3:0] d;
    d = (v - VEC_CH_BASE) >> 1;
    vec_idx = 2'(d + 4'h1);
  endfunction

  logic [IRQ_W-1:0] stat_r;
  logic [IRQ_W-1:0] mask_r;
  // Nets: each timer drives its own slice
  wire [IRQ_W-1:0] set_ev;
  wire [IRQ_W-1:0] vec_clr;
  logic [31:0] tmr_rdata [2];
  logic [3:0] vec_w [2];

  ////////////////////////////////////////////////////////////////////////////
  // Timers

  genvar t, c;
  generate
    for (t = 0; t < 2; t++) begin : g_tmr
      udt_ctrl_t ctrl_r;
      logic [CNT_W-1:0] cnt_r;
      logic first_r;
      logic src_q_r;
      logic [CNT_W-1:0] ccr_r [NUM_CH];
      logic [NUM_CH-1:0] cmp_mode_r;
      wire sel_t = ~glob & (tsel == 1'(t));
      wire ctl_wr = apb_wr & sel_t & (loc == OFF_CTRL);
      wire cnt_wr = apb_wr & sel_t & (loc == OFF_COUNT);
      wire clr_ev = ctl_wr & pwdata_i[CTL_CLR_BIT];
      wire ext_clk = (t == 0) ? external_count_clock_first_i
                              : external_count_clock_second_i;
      logic src_lvl;
      always_comb begin
        case (ctrl_r.src)
          SRC_INV_INPUT: src_lvl = ~inverted_input_clock_i[t];
          SRC_SUBSYSTEM: src_lvl = subsystem_clock_i;
          SRC_AUX: src_lvl = aux_clock_i;
          default: src_lvl = ext_clk;
        endcase
      end
      wire src_rise = src_lvl & ~src_q_r;
      // Prescaler of 1,2,4,8 built from a 3-bit view
      logic [2:0] psc_r;
      wire [2:0] psc_lim = 3'((4'b0001 << ctrl_r.div) - 4'b0001);
      wire tick = ctrl_r.run & src_rise & (first_r | (psc_r == psc_lim));
      wire at_top = (cnt_r == ccr_r[0]);
      wire roll = tick & at_top;
      wire [CNT_W-1:0] cnt_nxt = roll ? CNT_RST : cnt_r + 16'h0001;

      // Edge detector runs while stopped too, so a start sees no stale
      // level as an edge; the reset value only matters while stopped
      always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
          src_q_r <= 1'b0;
        end else begin
          src_q_r <= src_lvl;
        end
      end

      // Prescaler restarts at every clear and after every increment
      always_ff @(posedge core_clk_i) begin
        if (reset_i || clr_ev) begin
          psc_r <= 3'h0;
          first_r <= 1'b1;
        end else if (tick) begin
          psc_r <= 3'h0;
          first_r <= 1'b0;
        end else if (ctrl_r.run && src_rise) begin
          psc_r <= psc_r + 3'h1;
        end
      end

      // Clear beats a bus write, a bus write beats a tick
      always_ff @(posedge core_clk_i) begin
        if (reset_i || clr_ev) begin
          cnt_r <= CNT_RST;
        end else if (cnt_wr) begin
          cnt_r <= pwdata_i[CNT_W-1:0];
        end else if (tick) begin
          cnt_r <= cnt_nxt;
        end
      end

      // Clear bit is a strobe and is never stored
      always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
          ctrl_r <= '0;
        end else if (ctl_wr) begin
          ctrl_r.src <= pwdata_i[CTL_SRC_LSB +: 2];
          ctrl_r.div <= pwdata_i[CTL_DIV_LSB +: 2];
          ctrl_r.run <= pwdata_i[CTL_MODE_BIT];
        end
      end

      for (c = 0; c < NUM_CH; c++) begin : g_ch
        wire ccr_wr = apb_wr & sel_t & (loc == OFF_CCR0 + 8'(4 * c));
        wire cctl_wr = apb_wr & sel_t & (loc == OFF_CCTL0 + 8'(4 * c));
        always_ff @(posedge core_clk_i) begin
          if (reset_i) begin
            ccr_r[c] <= CNT_RST;
            cmp_mode_r[c] <= 1'b1;
          end else begin
            if (ccr_wr) begin
              ccr_r[c] <= pwdata_i[CNT_W-1:0];
            end
            if (cctl_wr) begin
              cmp_mode_r[c] <= pwdata_i[CCTL_CMP_BIT];
            end
          end
        end
        // Match seen as the counter steps onto the compare value; a value
        // moved onto the current count waits for the next step, so
        // software parks the channel in capture mode while moving it
        assign set_ev[t*IRQ_PER_TMR + 1 + c] = tick & cmp_mode_r[c] &
          (cnt_nxt == ccr_r[c]);
      end
      assign set_ev[t*IRQ_PER_TMR] = roll;

      // Vector: highest priority pending channel, then rollover
      wire [IRQ_PER_TMR-1:0] pend = stat_r[t*IRQ_PER_TMR +: IRQ_PER_TMR];
      always_comb begin
        vec_w[t] = VEC_NONE;
        if (pend[0]) begin
          vec_w[t] = VEC_ROLL;
        end
        for (int k = NUM_CH; k >= 1; k--) begin
          if (pend[k]) begin
            vec_w[t] = 4'(VEC_CH_BASE + 4'(2 * (k - 1)));
          end
        end
      end
      wire vec_rd = apb_rd & sel_t & (loc == OFF_VECTOR);

      // Local clear vector keeps each timer the only driver of its slice
      logic [IRQ_PER_TMR-1:0] clr_loc;
      always_comb begin
        clr_loc = '0;
        if (ctl_wr) begin
          clr_loc = '1;
        end else if (vec_rd && vec_w[t] == VEC_ROLL) begin
          clr_loc[0] = 1'b1;
        end else if (vec_rd && vec_w[t] != VEC_NONE) begin
          clr_loc[vec_idx(vec_w[t])] = 1'b1;
        end
      end
      assign vec_clr[t*IRQ_PER_TMR +: IRQ_PER_TMR] = clr_loc;

      always_comb begin
        tmr_rdata[t] = '0;
        case (loc)
          OFF_CTRL: tmr_rdata[t] = {26'h0, ctrl_r.run, ctrl_r.div,
                                    ctrl_r.src};
          OFF_COUNT: tmr_rdata[t] = {16'h0, cnt_r};
          OFF_VECTOR: tmr_rdata[t] = {28'h0, vec_w[t]};
          default: begin
            // Holes in the window read zero
            if (in_bank(loc, OFF_CCR0)) begin
              tmr_rdata[t] = {16'h0, ccr_r[ch_of(loc)]};
            end else if (in_bank(loc, OFF_CCTL0)) begin
              tmr_rdata[t] = {31'h0, cmp_mode_r[ch_of(loc)]};
            end
          end
        endcase
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt status, mask and bus response

  wire st_wr = apb_wr & (paddr_i == OFF_IRQ_STATUS);
  wire mk_wr = apb_wr & (paddr_i == OFF_IRQ_MASK);
  wire [IRQ_W-1:0] w1c = st_wr ? pwdata_i[IRQ_W-1:0] : '0;
  // Set wins so an event in the clearing cycle is kept
  wire [IRQ_W-1:0] stat_nxt = set_ev | (stat_r & ~w1c & ~vec_clr);

  logic [31:0] rd_mux;
  always_comb begin
    if (paddr_i == OFF_IRQ_STATUS)
      rd_mux = {{(32-IRQ_W){1'b0}}, stat_r};
    else if (paddr_i == OFF_IRQ_MASK)
      rd_mux = {{(32-IRQ_W){1'b0}}, mask_r};
    else if (!glob)
      rd_mux = tmr_rdata[tsel];
    else
      rd_mux = '0;
  end

  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      stat_r <= '0;
      mask_r <= '0;
    end else begin
      stat_r <= stat_nxt;
      if (mk_wr) begin
        mask_r <= pwdata_i[IRQ_W-1:0];
      end
    end
  end

  // New mask taken in its write cycle, so the line never shows a
  // stale level for a cycle after masking
  wire [IRQ_W-1:0] mask_nxt = mk_wr ? pwdata_i[IRQ_W-1:0] : mask_r;

  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= |(stat_nxt & mask_nxt);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Bus response: read data latched in setup, so access is wait-free

  wire rd_setup = psel_i & ~penable_i & ~pwrite_i;

  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      prdata_o <= '0;
      pready_o <= 1'b0;
      pslverr_o <= 1'b0;
    end else begin
      pready_o <= psel_i & ~penable_i;
      pslverr_o <= 1'b0;
      if (rd_setup) begin
        prdata_o <= rd_mux;
      end
    end
  end

endmodule

// File: verification/udt_props.sv
// Port checks of the timer unit.
// Bound into udt_timer_unit; sees its ports only.
`timescale 1ns/1ps
module udt_props (
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic reset_i,
  // APB
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [31:0] prdata_o,
  input wire logic pready_o,
  input wire logic pslverr_o,
  // Interrupt
  input wire logic irq_o
);
  default clocking cb @(posedge core_clk_i); endclocking
  wire rd_setup = psel_i && !penable_i && !pwrite_i;
  wire [7:0] reg_off = paddr_i & 8'hBF;
  ////////////////////////////////////////
  chk_ready_setup: assert property (disable iff (reset_i)
    psel_i && !penable_i |=> pready_o) else $error("ready late");
  chk_ready_access: assert property (disable iff (reset_i)
    pready_o |-> psel_i && penable_i) else $error("stray ready");
  chk_ready_pulse: assert property (disable iff (reset_i)
    pready_o |=> !pready_o) else $error("ready too long");
  chk_no_error: assert property (disable iff (reset_i)
    !pslverr_o) else $error("error response");
  chk_reset_idle: assert property (reset_i |=>
    !irq_o && !pready_o && prdata_o == 32'h0) else $error("not idle");
  chk_unmapped_zero: assert property (disable iff (reset_i)
    rd_setup && paddr_i >= 8'h88 |=> prdata_o == 32'h0)
    else $error("unmapped data");
  chk_vector_code: assert property (disable iff (reset_i)
    rd_setup && reg_off == 8'h08 |=> prdata_o inside
    {32'h0, 32'h2, 32'h4, 32'h6, 32'hA}) else $error("bad vector");
  chk_clear_bit: assert property (disable iff (reset_i)
    rd_setup && reg_off == 8'h00 |=> !prdata_o[5])
    else $error("clear bit reads one");
  chk_mask_off: assert property (disable iff (reset_i)
    psel_i && penable_i && pwrite_i && paddr_i == 8'h84
    && pwdata_i[7:0] == 8'h00 |-> ##2 !irq_o) else $error("irq masked");
endmodule

bind udt_timer_unit udt_props i_udt_props (.*);

// File: verification/testbench.sv
// Self-checking bench of the timer unit over APB.
// One bench signal gives every count source one edge per tick.
`timescale 1ns/1ps
module testbench;
  import udt_pkg::*;
  logic clk = 0, rst = 1, s = 0, psel = 0, pen = 0, pwr = 0;
  logic [7:0] pa = 8'h00, b;
  logic [31:0] pwd = 32'h0, prd, rd;
  logic prdy, perr, irq;
  integer seed = 32'hC502AAD8;
  int bad_count = 0, check_count = 0, p, c;
  logic [31:0] vc [5] = '{32'h2, 32'h4, 32'h6, 32'hA, 32'h0};
  udt_timer_unit i_udt_timer_unit (.core_clk_i(clk), .reset_i(rst),
    .inverted_input_clock_i({2{s}}), .subsystem_clock_i(s),
    .aux_clock_i(s), .external_count_clock_first_i(s),
    .external_count_clock_second_i(s), .psel_i(psel), .penable_i(pen),
    .pwrite_i(pwr), .paddr_i(pa), .pwdata_i(pwd), .prdata_o(prd),
    .pready_o(prdy), .pslverr_o(perr), .irq_o(irq));
  initial forever #2.5 clk = ~clk;
  ////////////////////////////////////////
  task automatic cmp(input logic [31:0] g, input logic [31:0] e);
    check_count++;
    if (g !== e) begin
      bad_count++;
      $display("mismatch %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a,
      input logic [31:0] wd);
    psel <= 1'b1;
    pwr <= w;
    pa <= a;
    pwd <= wd;
    @(posedge clk);
    pen <= 1'b1;
    do @(posedge clk); while (prdy !== 1'b1);
    rd = prd;
    psel <= 1'b0;
    pen <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    cmp(rd, e);
  endtask
  task automatic tk(input int n);
    repeat (n) begin
      s <= 1'b1;
      repeat (2) @(posedge clk);
      s <= 1'b0;
      repeat (2) @(posedge clk);
    end
  endtask
  // Ticks to reach count n: first one ignores the divider
  function automatic int need(input int n, input int dv);
    return 1 + ((n - 1) << dv);
  endfunction
  task automatic print_verdict;
    if (bad_count == 0 && check_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  ////////////////////////////////////////
  initial begin
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rdc(OFF_COUNT + TIMER_STRIDE, 32'h0);
    rdc(8'hC0, 32'h0);
    for (int k = 0; k < 4; k++) begin
      b = k[0] ? TIMER_STRIDE : 8'h00;
      p = 2 + {$random(seed)} % 4;
      c = 1 + {$random(seed)} % (p - 1);
      bus(1'b1, b + OFF_CCR0, 32'(p));
      bus(1'b1, b + OFF_CCR0 + 8'h04, 32'(c));
      bus(1'b1, OFF_IRQ_MASK, 32'hFF);
      bus(1'b1, b + OFF_CTRL, 32'(k | k << 2 | 'h30));
      tk(need(p, k));
      rdc(b + OFF_COUNT, 32'(p));
      rdc(OFF_IRQ_STATUS, 32'h6 << (4 * k[0]));
      tk(1 << k);
      rdc(b + OFF_COUNT, 32'h0);
      rdc(OFF_IRQ_STATUS, 32'hF << (4 * k[0]));
      cmp(32'(irq), 32'h1);
      bus(1'b1, OFF_IRQ_MASK, 32'h0);
      @(posedge clk);
      cmp(32'(irq), 32'h0);
      bus(1'b1, OFF_IRQ_MASK, 32'hFF);
      for (int j = 0; j < 5; j++) begin
        if (k[1] && j == 1) bus(1'b1, b + OFF_CTRL, 32'h10);
        rdc(b + OFF_VECTOR, (k[1] && j > 0) ? 32'h0 : vc[j]);
      end
      @(posedge clk);
      cmp(32'(irq), 32'h0);
      bus(1'b1, b + OFF_CTRL, 32'h0);
    end
    // Capture mode parks a channel while its compare value moves
    bus(1'b1, OFF_CCR0, 32'h5);
    bus(1'b1, OFF_CCR0 + 8'h04, 32'h2);
    bus(1'b1, OFF_CCTL0 + 8'h04, 32'h0);
    bus(1'b1, OFF_CTRL, 32'h31);
    tk(2);
    rdc(OFF_IRQ_STATUS, 32'h0);
    bus(1'b1, OFF_CCR0 + 8'h04, 32'h3);
    bus(1'b1, OFF_CCTL0 + 8'h04, 32'h1);
    tk(1);
    rdc(OFF_IRQ_STATUS, 32'h4);
    cmp(32'(irq), 32'h1);
    bus(1'b1, OFF_CTRL, 32'h1);
    rdc(OFF_VECTOR, 32'h0);
    tk(2);
    rdc(OFF_COUNT, 32'h3);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rdc(OFF_COUNT, 32'h0);
    rdc(OFF_CTRL, 32'h0);
    print_verdict();
  end
  initial begin
    repeat (20000) @(posedge clk);
    bad_count++;
    print_verdict();
  end
endmodule
